// ==== logic/floating_point_coprocessor_decode_pkg.sv ====
// types shared by the coprocessor decoder
package floating_point_coprocessor_decode_pkg;
  typedef struct packed {
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic rm;
    logic [2:0] src;
    logic [2:0] dst;
    logic [6:0] opc;
    logic src_is_fmt;
    logic illegal;
  } decode_s;
  typedef enum logic [1:0] {OUT_NONE, OUT_NEXT, OUT_BRANCH, OUT_TRAP} outcome_e;
endpackage : floating_point_coprocessor_decode_pkg

// ==== logic/floating_point_coprocessor_decode_regs.svh ====
// register offsets, field positions and codes for the coprocessor decoder
`ifndef FLOATING_POINT_COPROCESSOR_DECODE_REGS_SVH
`define FLOATING_POINT_COPROCESSOR_DECODE_REGS_SVH
// register word addresses (one per 32-bit register)
`define REG_CTRL 4'h0
`define REG_OPWORD 4'h1
`define REG_EXTWORD 4'h2
`define REG_COUNT 4'h3
`define REG_PC 4'h4
`define REG_DISP 4'h5
`define REG_STATUS 4'h6
`define REG_DECODE 4'h7
`define REG_RESULT 4'h8
`define REG_TARGET 4'h9
// control register fields
`define CTRL_ID_LSB 0
`define CTRL_GO_BIT 4
`define CTRL_CLR_BIT 5
`define CTRL_ID_RST 3'h1
// status register fields
`define ST_CC_LSB 0
`define ST_NAN_BIT 0
`define ST_Q_LSB 8
`define ST_EXC_LSB 16
`define ST_BRANCH_UNORDERED_FLAG_BIT 23
`define ST_ACC_LSB 24
`define ST_IOP_BIT 31
// first word fields
`define W_ID_LSB 9
`define W_TYPE_LSB 6
`define W_MODE_LSB 3
`define W_REG_LSB 0
// extension word fields
`define X_RM_BIT 14
`define X_SRC_LSB 10
`define X_DST_LSB 7
`define X_OPC_LSB 0
// effective address modes
`define EA_DREG 3'h0
`define EA_AREG 3'h1
`define EA_IND 3'h2
`define EA_POST 3'h3
`define EA_PRE 3'h4
`define EA_DISP 3'h5
`define EA_INDEX 3'h6
`define EA_ABS 3'h7
// source formats
`define FMT_LONG 3'h0
`define FMT_SINGLE 3'h1
`define FMT_EXT 3'h2
`define FMT_PACKED 3'h3
`define FMT_WORD 3'h4
`define FMT_DOUBLE 3'h5
`define FMT_BYTE 3'h6
`define FMT_BAD 3'h7
// instruction type codes in bits 8:6 of first word
`define TYPE_GEN 3'h0
`define TYPE_DBCC 3'h1
// opcodes for divide and cosh in general extension word, then pc step and loop end count
`define OPC_DIV 7'h20
`define OPC_COSH 7'h19
`define PC_STEP 32'h0000_0002
`define CNT_END 16'hFFFF
`endif

// ==== logic/fp_cond_eval.sv ====
// evaluator of the 32 floating-point conditional tests
`timescale 1ns/10ps
`include "floating_point_coprocessor_decode_regs.svh"
module fp_cond_eval
  import floating_point_coprocessor_decode_pkg::*;
(
  // condition codes n z i nan
  input wire logic [3:0] i_cc,
  input wire logic [5:0] i_sel,
  // result
  output logic o_true,
  output logic o_unordered_trap
);
  logic n, z, nan;
  logic base;
  always_comb begin
    n = i_cc[3];
    z = i_cc[2];
    nan = i_cc[`ST_NAN_BIT];
    // low four bits pick the predicate, bit 4 selects the non-aware set
    unique case (i_sel[3:0])
      4'h0: base = 1'b0;
      4'h1: base = z;
      4'h2: base = ~(nan | z | n);
      4'h3: base = z | ~(nan | n);
      4'h4: base = n & ~(nan | z);
      4'h5: base = z | (n & ~nan);
      4'h6: base = ~(nan | z);
      4'h7: base = ~nan;
      4'h8: base = nan;
      4'h9: base = nan | z;
      4'hA: base = nan | ~(n | z);
      4'hB: base = nan | z | ~n;
      4'hC: base = nan | (n & ~z);
      4'hD: base = nan | z | n;
      4'hE: base = ~z;
      default: base = 1'b1;
    endcase
    // non-aware tests trap on unordered operands
    o_unordered_trap = i_sel[4] & nan;
    o_true = base;
  end
endmodule : fp_cond_eval

// ==== logic/fp_coproc_decode_loop_branch.sv ====
// coprocessor instruction decoder and decrement-and-branch loop unit
// Behaviour
// - execute only when the coprocessor id field matches our own id
// - decode address modes 000,010,011,100,101,110,111; address register direct refused
// - data register direct allowed only for byte, word, long, single
// - select bit 0 means register to register, 1 means address to register
// - select 0 makes the source field the source fp register number
// - select 1 makes the source field the operand format code
// - destination field names the target; equal fields read and write one register
// - loop condition true means fall through with no decrement
// - condition false decrements low 16 counter bits, upper bits kept
// - decremented count of -1 falls through, otherwise branch
// - branch base is instruction address plus 2, displacement in bytes
// - condition select picks one of 32 tests against condition codes
// - loop leaves codes and quotient; unordered flag only on nan with non-aware test
// - unordered flag also sets accrued invalid flag, nothing else accrued
// - count register field names the processor data register for the counter
`timescale 1ns/10ps
`include "floating_point_coprocessor_decode_regs.svh"
module fp_coproc_decode_loop_branch
  import floating_point_coprocessor_decode_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // results
  output logic o_busy,
  output logic o_trap
);
  // register state
  logic [2:0] id_q, id_d;
  logic [15:0] op_q, op_d, ext_q, ext_d, disp_q, disp_d;
  logic [31:0] cnt_q, cnt_d, pc_q, pc_d, stat_q, stat_d, tgt_q, tgt_d;
  logic [31:0] dec_q, dec_d, rdata_q, rdata_d;
  logic wait_q, wait_d, busy_q, busy_d, trap_q, trap_d;
  logic [1:0] res_q, res_d;
  // handshake: one wait cycle, then answer
  typedef enum logic [1:0] {ST_IDLE, ST_ACK} bus_e;
  bus_e bus_q, bus_d;

  decode_s dec;
  logic cond_true, cond_trap;
  logic id_match;
  logic [15:0] cnt_low;
  logic [31:0] disp_ext;
  outcome_e outcome;

  fp_cond_eval u_cond (
    .i_cc(stat_q[`ST_CC_LSB+3:`ST_CC_LSB]),
    .i_sel(ext_q[5:0]),
    .o_true(cond_true),
    .o_unordered_trap(cond_trap)
  );

  function automatic logic ea_legal(input logic [2:0] mode, input logic [2:0] fmt);
    unique case (mode)
      `EA_DREG: ea_legal = (fmt == `FMT_LONG) || (fmt == `FMT_SINGLE) ||
                           (fmt == `FMT_WORD) || (fmt == `FMT_BYTE);
      `EA_IND, `EA_POST, `EA_PRE, `EA_DISP, `EA_INDEX, `EA_ABS: ea_legal = 1'b1;
      default: ea_legal = 1'b0;
    endcase
  endfunction : ea_legal

  // register read decode, evaluated with the grant, one edge before the read is taken
  function automatic logic [31:0] reg_read(input logic [3:0] addr);
    unique case (addr)
      `REG_CTRL: reg_read = {26'h0, trap_q, busy_q, 1'b0, id_q};
      `REG_OPWORD: reg_read = {16'h0000, op_q};
      `REG_EXTWORD: reg_read = {16'h0000, ext_q};
      `REG_COUNT: reg_read = cnt_q;
      `REG_PC: reg_read = pc_q;
      `REG_DISP: reg_read = {16'h0000, disp_q};
      `REG_STATUS: reg_read = stat_q;
      `REG_DECODE: reg_read = dec_q;
      `REG_RESULT: reg_read = {28'h0000000, 2'(res_q), 2'(res_q)};
      `REG_TARGET: reg_read = tgt_q;
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  // instruction decode
  always_comb begin
    dec = '0;
    dec.opc = ext_q[`X_OPC_LSB+6:`X_OPC_LSB];
    dec.rm = ext_q[`X_RM_BIT];
    dec.src = ext_q[`X_SRC_LSB+2:`X_SRC_LSB];
    dec.dst = ext_q[`X_DST_LSB+2:`X_DST_LSB];
    // format when select is 1, register number otherwise
    dec.src_is_fmt = dec.rm;
    // address field ignored for register form
    dec.ea_mode = dec.rm ? op_q[`W_MODE_LSB+2:`W_MODE_LSB] : 3'h0;
    // loop form carries the counter's data register number here
    dec.ea_reg = (dec.rm || op_q[`W_TYPE_LSB+2:`W_TYPE_LSB] == `TYPE_DBCC) ?
                 op_q[`W_REG_LSB+2:`W_REG_LSB] : 3'h0;
    dec.illegal = dec.rm &&
                  ((dec.src == `FMT_BAD) || !ea_legal(dec.ea_mode, dec.src));
  end

  always_comb begin
    id_match = (op_q[`W_ID_LSB+2:`W_ID_LSB] == id_q);
    cnt_low = cnt_q[15:0] - 16'h0001;
    disp_ext = {{16{disp_q[15]}}, disp_q};
  end

  // register and execution next state
  always_comb begin
    id_d = id_q;
    op_d = op_q;
    ext_d = ext_q;
    disp_d = disp_q;
    cnt_d = cnt_q;
    pc_d = pc_q;
    stat_d = stat_q;
    tgt_d = tgt_q;
    dec_d = dec_q;
    res_d = res_q;
    busy_d = 1'b0;
    trap_d = trap_q;
    wait_d = 1'b1;
    bus_d = bus_q;
    rdata_d = rdata_q;
    outcome = OUT_NONE;
    unique case (bus_q)
      ST_IDLE: begin
        wait_d = 1'b1;
        if (i_avs_read || i_avs_write) begin
          bus_d = ST_ACK;
          wait_d = 1'b0;
        end
        // loaded with the grant so the data stand while waitrequest is low
        if (i_avs_read) begin
          rdata_d = reg_read(i_avs_address);
        end
      end
      ST_ACK: begin
        bus_d = ST_IDLE;
        wait_d = 1'b1;
        if (i_avs_write) begin
          unique case (i_avs_address)
            `REG_CTRL: begin
              id_d = i_avs_writedata[`CTRL_ID_LSB+2:`CTRL_ID_LSB];
              if (i_avs_writedata[`CTRL_CLR_BIT]) begin
                trap_d = 1'b0;
              end
              if (i_avs_writedata[`CTRL_GO_BIT]) begin
                busy_d = 1'b1;
                trap_d = 1'b0;
                // keep the fields of every instruction addressed to us
                if (id_match) begin
                  dec_d = {10'h000, dec};
                end
                if (!id_match) begin
                  res_d = OUT_NONE;
                end else if (op_q[`W_TYPE_LSB+2:`W_TYPE_LSB] == `TYPE_DBCC) begin
                  // counter supplied from named data register
                  // unordered flag set on nan with non-aware test
                  if (cond_trap) begin
                    stat_d[`ST_BRANCH_UNORDERED_FLAG_BIT] = 1'b1;
                    stat_d[`ST_IOP_BIT] = 1'b1;
                  end
                  if (cond_true) begin
                    outcome = OUT_NEXT;
                  end else begin
                    cnt_d = {cnt_q[31:16], cnt_low};
                    outcome = (cnt_low == `CNT_END) ? OUT_NEXT : OUT_BRANCH;
                  end
                  if (cond_trap) begin
                    outcome = OUT_TRAP;
                    trap_d = 1'b1;
                  end
                  res_d = outcome;
                  // target is pc plus 2 plus displacement
                  tgt_d = pc_q + `PC_STEP + disp_ext;
                end else if (dec.illegal) begin
                  res_d = OUT_TRAP;
                  trap_d = 1'b1;
                end else begin
                  // divide and other general ops accepted for execution
                  res_d = OUT_NEXT;
                end
              end
            end
            `REG_OPWORD: op_d = i_avs_writedata[15:0];
            `REG_EXTWORD: ext_d = i_avs_writedata[15:0];
            `REG_COUNT: cnt_d = i_avs_writedata;
            `REG_PC: pc_d = i_avs_writedata;
            `REG_DISP: disp_d = i_avs_writedata[15:0];
            `REG_STATUS: stat_d = i_avs_writedata;
            default: ;
          endcase
        end
      end
      default: bus_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      id_q <= `CTRL_ID_RST;
      op_q <= 16'h0000;
      ext_q <= 16'h0000;
      disp_q <= 16'h0000;
      cnt_q <= 32'h0000_0000;
      pc_q <= 32'h0000_0000;
      stat_q <= 32'h0000_0000;
      tgt_q <= 32'h0000_0000;
      dec_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      res_q <= 2'h0;
      busy_q <= 1'b0;
      trap_q <= 1'b0;
      wait_q <= 1'b1;
      bus_q <= ST_IDLE;
    end else begin
      id_q <= id_d;
      op_q <= op_d;
      ext_q <= ext_d;
      disp_q <= disp_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      stat_q <= stat_d;
      tgt_q <= tgt_d;
      dec_q <= dec_d;
      rdata_q <= rdata_d;
      res_q <= res_d;
      busy_q <= busy_d;
      trap_q <= trap_d;
      wait_q <= wait_d;
      bus_q <= bus_d;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_busy = busy_q;
  assign o_trap = trap_q;
endmodule : fp_coproc_decode_loop_branch

// ==== tb/fp_coproc_decode_loop_branch_assertions.sv ====
// bus, busy and trap assertions for the decoder and loop unit
`timescale 1ns/10ps
`include "floating_point_coprocessor_decode_regs.svh"
module fp_coproc_decode_loop_branch_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register bus
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // results
  input wire logic o_busy,
  input wire logic o_trap
);
  logic [2:0] age_q, age_d;
  logic ctl;
  // cycles since a control write was taken, saturating
  assign ctl = i_avs_write && !o_avs_waitrequest && i_avs_address == `REG_CTRL;
  always_comb begin
    age_d = ctl ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      age_q <= 3'h7;
    end else begin
      age_q <= age_d;
    end
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  property p_ack_once;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than a cycle");
  property p_ack_cause;
    $fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_req_ans;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_req_ans: assert property (p_req_ans) else $error("request not answered");
  property p_unmapped;
    i_avs_read && !o_avs_waitrequest && i_avs_address > 4'h9 |-> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold;
    $changed(o_avs_readdata) |-> $past(i_avs_read);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_busy_go;
    ctl && i_avs_writedata[`CTRL_GO_BIT] |-> ##[0:2] o_busy;
  endproperty
  a_busy_go: assert property (p_busy_go) else $error("no busy after start");
  property p_busy_pulse;
    o_busy |=> !o_busy;
  endproperty
  a_busy_pulse: assert property (p_busy_pulse) else $error("busy too long");
  property p_trap_clr;
    ctl && i_avs_writedata[`CTRL_CLR_BIT] && !i_avs_writedata[`CTRL_GO_BIT] |-> ##[1:3] !o_trap;
  endproperty
  a_trap_clr: assert property (p_trap_clr) else $error("trap not cleared");
  property p_trap_cause;
    $changed(o_trap) |-> age_q < 3'h4;
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap moved unprompted");
  c_busy: cover property (o_busy);
  c_trap: cover property ($rose(o_trap));
  c_unmapped: cover property (i_avs_read && !o_avs_waitrequest && i_avs_address > 4'h9);
endmodule : fp_coproc_decode_loop_branch_chk

bind fp_coproc_decode_loop_branch fp_coproc_decode_loop_branch_chk u_chk (.i_clk, .i_rst,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
  .o_avs_waitrequest, .o_busy, .o_trap);

// ==== tb/fp_main_proc_model.sv ====
// main processor model issuing coprocessor work over the register bus
`timescale 1ns/10ps
`include "floating_point_coprocessor_decode_regs.svh"
module fp_main_proc_model (
  // clock
  input wire logic i_clk,
  // bus master
  output logic [3:0] o_avs_address,
  output logic o_avs_read,
  output logic o_avs_write,
  output logic [31:0] o_avs_writedata,
  input wire logic [31:0] i_avs_readdata,
  input wire logic i_avs_waitrequest,
  // slave never answered
  output logic o_hang
);
  initial begin
    o_avs_address = 4'h0;
    o_avs_read = 1'b0;
    o_avs_write = 1'b0;
    o_avs_writedata = 32'h0;
    o_hang = 1'b0;
  end
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    o_avs_address <= a;
    o_avs_read <= !w;
    o_avs_write <= w;
    o_avs_writedata <= d;
    // read before this edge's updates land, so the ack edge is the one seen
    do begin
      @(posedge i_clk);
      n++;
    end while (i_avs_waitrequest !== 1'b0 && n < 64);
    q = i_avs_readdata;
    o_hang <= (n >= 64);
    o_avs_read <= 1'b0;
    o_avs_write <= 1'b0;
    // released lines carry no stale value
    o_avs_address <= ~a;
    o_avs_writedata <= ~d;
  endtask : xfer
  task automatic issue(input logic [15:0] opw, input logic [15:0] ext);
    logic [31:0] q;
    if (opw[8:6] == `TYPE_GEN && !ext[`X_RM_BIT])
      opw[5:0] = 6'h0;
    xfer(1'b1, `REG_OPWORD, {16'h0, opw}, q);
    xfer(1'b1, `REG_EXTWORD, {16'h0, ext}, q);
    xfer(1'b1, `REG_CTRL, 32'h11, q);
  endtask : issue
endmodule : fp_main_proc_model

// ==== tb/test_fp_coproc_decode_loop_branch.sv ====
// self-checking bench for the decoder and loop unit
`timescale 1ns/10ps
`include "floating_point_coprocessor_decode_regs.svh"
module test_fp_coproc_decode_loop_branch
  import floating_point_coprocessor_decode_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_avs_address;
  logic i_avs_read, i_avs_write, o_avs_waitrequest, o_busy, o_trap, hang;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  int n_fail = 0;
  int checked = 0;
  int seed;
  always #50 i_clk = ~i_clk;
  fp_coproc_decode_loop_branch dut (.i_clk, .i_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_busy, .o_trap);
  fp_main_proc_model pm (.i_clk, .o_avs_address(i_avs_address), .o_avs_read(i_avs_read),
    .o_avs_write(i_avs_write), .o_avs_writedata(i_avs_writedata),
    .i_avs_readdata(o_avs_readdata), .i_avs_waitrequest(o_avs_waitrequest), .o_hang(hang));
  task automatic wrap_up;
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  always @(posedge hang) begin
    n_fail++;
    wrap_up;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdm(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
      input string nm);
    logic [31:0] v;
    pm.xfer(1'b0, a, 32'h0, v);
    chk(nm, e, v & m);
  endtask : rdm
  function automatic logic [1:0] gen_out(input logic [2:0] id, input logic ill);
    gen_out = (id != 3'h1) ? 2'(OUT_NONE) : ill ? 2'(OUT_TRAP) : 2'(OUT_NEXT);
  endfunction : gen_out
  function automatic logic [1:0] loop_out(input logic tr, input logic bs, input logic [15:0] c);
    loop_out = bs ? 2'(OUT_TRAP) : (tr || c == `CNT_END) ? 2'(OUT_NEXT) : 2'(OUT_BRANCH);
  endfunction : loop_out
  task automatic gen(input logic [2:0] id, input logic rm, input logic [2:0] md,
      input logic [2:0] src, input logic [2:0] dst, input logic [6:0] opc);
    logic ill;
    ill = rm && (md == `EA_AREG || src == `FMT_BAD || (md == `EA_DREG &&
      (src == `FMT_EXT || src == `FMT_PACKED || src == `FMT_DOUBLE))) && id == 3'h1;
    pm.issue({4'hF, id, `TYPE_GEN, md, 3'h5}, {1'b0, rm, 1'b0, src, dst, opc});
    rdm(`REG_CTRL, 32'h2F, {26'h0, ill, 5'h1}, "ctrl");
    chk("trap", {31'h0, ill}, {31'h0, o_trap});
    rdm(`REG_RESULT, 32'hF, {28'h0, gen_out(id, ill), gen_out(id, ill)}, "result");
    if (id == 3'h1)
      rdm(`REG_DECODE, 32'hFFFF, {16'h0, rm, src, dst, opc, rm, ill}, "decode");
  endtask : gen
  task automatic lp(input logic [5:0] sel, input logic [31:0] cnt, input logic [31:0] pc,
      input logic [15:0] dsp, input logic [31:0] st);
    logic [31:0] q, ec;
    logic tr, bs;
    logic [1:0] oc;
    tr = sel[3:0] == 4'hF;
    bs = sel[4] && st[`ST_NAN_BIT];
    ec = tr ? cnt : {cnt[31:16], cnt[15:0] - 16'h1};
    oc = loop_out(tr, bs, ec[15:0]);
    pm.xfer(1'b1, `REG_COUNT, cnt, q);
    pm.xfer(1'b1, `REG_PC, pc, q);
    pm.xfer(1'b1, `REG_DISP, {16'h0, dsp}, q);
    pm.xfer(1'b1, `REG_STATUS, st, q);
    pm.issue({4'hF, 3'h1, `TYPE_DBCC, 3'h1, cnt[2:0]}, {10'h0, sel});
    rdm(`REG_COUNT, 32'hFFFF_FFFF, ec, "count");
    rdm(`REG_RESULT, 32'h3, {30'h0, oc}, "outcome");
    rdm(`REG_DECODE, 32'h0007_0000, {13'h0, cnt[2:0], 16'h0}, "count reg");
    if (oc == OUT_BRANCH)
      rdm(`REG_TARGET, 32'hFFFF_FFFF, pc + `PC_STEP + {{16{dsp[15]}}, dsp}, "target");
    rdm(`REG_STATUS, 32'hFFFF_FFFF, st | (bs ? 32'h8080_0000 : 32'h0), "status");
    chk("trap", {31'h0, bs}, {31'h0, o_trap});
  endtask : lp
  initial begin
    logic [31:0] r;
    seed = 32'h6C07;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    rdm(`REG_CTRL, 32'hFFFF_FFFF, 32'h1, "reset ctrl");
    pm.xfer(1'b1, 4'hC, 32'hFFFF_FFFF, r);
    rdm(4'hC, 32'hFFFF_FFFF, 32'h0, "unmapped");
    for (int m = 0; m < 7; m++)
      gen(3'h1, 1'b1, m[2:0], 3'h5, 3'h2, `OPC_DIV);
    for (int f = 0; f < 8; f++)
      gen(3'h1, 1'b1, `EA_DREG, f[2:0], 3'h3, `OPC_COSH);
    gen(3'h1, 1'b0, 3'h0, 3'h4, 3'h4, `OPC_DIV);
    gen(3'h2, 1'b1, `EA_AREG, 3'h0, 3'h1, `OPC_DIV);
    repeat (40) begin
      r = $random(seed);
      gen(r[2:0] == 3'h0 ? 3'h3 : 3'h1, r[3], r[6:4] == 3'h7 ? `EA_INDEX : r[6:4], r[9:7],
        r[12:10], r[13] ? `OPC_DIV : `OPC_COSH);
    end
    lp(6'h00, 32'hABCD_0000, 32'h0000_1000, 16'hFFF0, 32'h0);
    lp(6'h00, 32'h0000_0001, 32'h0000_1000, 16'h0010, 32'h0);
    lp(6'h0F, 32'h0000_0005, 32'h0000_2000, 16'h0010, 32'h0100_0000);
    lp(6'h10, 32'h0000_0007, 32'h0000_3000, 16'h8000, 32'h0000_AB01);
    pm.xfer(1'b1, `REG_CTRL, 32'h21, r);
    rdm(`REG_CTRL, 32'h20, 32'h0, "trap clear");
    lp(6'h10, 32'h0000_0007, 32'h0000_3000, 16'h8000, 32'h0000_AB00);
    repeat (40) begin
      r = $random(seed);
      lp({1'b0, r[0], {4{r[1]}}}, $random(seed), $random(seed), r[31:16], $random(seed));
    end
    wrap_up;
  end
endmodule : test_fp_coproc_decode_loop_branch
